/* File: rtl/mlie_params.svh */
// constants for the literal/indirect move execution block
`ifndef MLIE_PARAMS_SVH
`define MLIE_PARAMS_SVH
`define MLIE_ADR_OPCODE    4'h0
`define MLIE_ADR_ACCUM     4'h1
`define MLIE_ADR_BANK      4'h2
`define MLIE_ADR_PCH       4'h3
`define MLIE_ADR_OPTION    4'h4
`define MLIE_ADR_PTR0      4'h5
`define MLIE_ADR_PTR1      4'h6
`define MLIE_ADR_STATUS    4'h7
`define MLIE_ADR_MEMADR    4'h8
`define MLIE_ADR_MEMDAT    4'h9
`define MLIE_ADR_SUPPLY    4'hA
`define MLIE_WIN0_ADDR     7'h00
`define MLIE_WIN1_ADDR     7'h01
`define MLIE_OPT_RESET     8'hFF
`define MLIE_OP_LSB        16
`define MLIE_MEM_DEPTH     256
`endif

/* File: rtl/mlie_pkg.sv */
// types for the literal/indirect move execution block
package mlie_pkg;
   typedef enum logic [3:0] {
      MLIE_NOP      = 4'h0,
      MLIE_MOVBANK  = 4'h1,
      MLIE_MOVPCH   = 4'h2,
      MLIE_MOVACC   = 4'h3,
      MLIE_STDIR    = 4'h4,
      MLIE_STIND    = 4'h5,
      MLIE_STREL    = 4'h6,
      MLIE_LDIND    = 4'h7,
      MLIE_LDREL    = 4'h8,
      MLIE_OPTION   = 4'h9,
      MLIE_SWRESET  = 4'hA
   } mlie_op_type;
   typedef enum logic [1:0] {
      MLIE_PREINC  = 2'b00,
      MLIE_PREDEC  = 2'b01,
      MLIE_POSTINC = 2'b10,
      MLIE_POSTDEC = 2'b11
   } mlie_mode_type;
endpackage : mlie_pkg

/* File: rtl/mlie_mem_if.sv */
// data memory port between core and store
`timescale 1ns/100ps
interface mlie_mem_if;
   logic        we;
   logic [15:0] wadr;
   logic [7:0]  wdat;
   logic [15:0] radr;
   logic [7:0]  rdat;
   modport core (output we, output wadr, output wdat, output radr, input rdat);
   modport mem  (input we, input wadr, input wdat, input radr, output rdat);
endinterface : mlie_mem_if

/* File: rtl/mlie_mem.sv */
// data memory, low 256 locations, combinational read
`timescale 1ns/100ps
`include "mlie_params.svh"
module mlie_mem (
   input  wire logic clk_i,
   mlie_mem_if.mem   bus
);
   logic [7:0] store_r [`MLIE_MEM_DEPTH];
   always_ff @(posedge clk_i) begin
      if (bus.we) begin
         store_r[bus.wadr[7:0]] <= bus.wdat;
      end
   end
   assign bus.rdat = store_r[bus.radr[7:0]];
endmodule : mlie_mem

/* File: rtl/mlie_exec.sv */
// wishbone-driven executor for literal, direct and indirect moves
//
// The register addresses and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "mlie_params.svh"
module mlie_exec (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [5:2]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             sw_reset_o
);
   import mlie_pkg::*;
   mlie_mem_if mif ();
   mlie_mem u_mem (.clk_i(clk_i), .bus(mif));

   logic [7:0]  accum_r, accum_nxt;
   logic [4:0]  bank_r, bank_nxt;
   logic [6:0]  pch_r, pch_nxt;
   logic [7:0]  option_r, option_nxt;
   logic [15:0] ptr_r [2];
   logic [15:0] ptr_nxt [2];
   logic        zero_r, zero_nxt;
   logic        carry_r, carry_nxt;
   logic        reset_instr_flag_n_r, reset_instr_flag_n_nxt;
   logic [15:0] madr_r, madr_nxt;
   logic        ack_r, ack_nxt;
   logic        swr_r, swr_nxt;
   logic [31:0] rdat_r, rdat_nxt;

   logic        req;
   logic        wr_op;
   mlie_op_type op;
   logic [7:0]  lit;
   logic        psel;
   mlie_mode_type pmode;
   logic [5:0]  offs;
   logic [6:0]  fadr;
   logic [15:0] eff;
   logic [15:0] upd;

   // effective address for a window access
   function automatic logic [15:0] win_adr(input logic [6:0] a, input logic [15:0] p0,
                                           input logic [15:0] p1, input logic [6:0] f);
      win_adr = (f == `MLIE_WIN0_ADDR) ? p0 : (f == `MLIE_WIN1_ADDR) ? p1 : {9'h000, a};
   endfunction : win_adr

   assign req   = wb_cyc_i & wb_stb_i & ~ack_r;
   assign wr_op = req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `MLIE_ADR_OPCODE);
   assign op    = mlie_op_type'(wb_dat_i[`MLIE_OP_LSB+3:`MLIE_OP_LSB]);
   assign lit   = wb_dat_i[7:0];
   assign fadr  = wb_dat_i[6:0];
   assign psel  = wb_dat_i[8];
   assign pmode = mlie_mode_type'(wb_dat_i[10:9]);
   assign offs  = wb_dat_i[5:0];
   // read port follows the pointer only for indirect and relative loads
   assign mif.radr = (op == MLIE_LDIND || op == MLIE_LDREL) ? eff : madr_r;

   always_comb begin
      unique case (pmode)
         MLIE_PREINC, MLIE_POSTINC : upd = ptr_r[psel] + 16'h0001;
         MLIE_PREDEC, MLIE_POSTDEC : upd = ptr_r[psel] - 16'h0001;
      endcase
      if (op == MLIE_STREL || op == MLIE_LDREL) begin
         eff = ptr_r[psel] + {{10{offs[5]}}, offs};
      end else if (pmode == MLIE_PREINC || pmode == MLIE_PREDEC) begin
         eff = upd;
      end else begin
         eff = ptr_r[psel];
      end
   end

   always_comb begin
      accum_nxt  = accum_r;
      bank_nxt   = bank_r;
      pch_nxt    = pch_r;
      option_nxt = option_r;
      ptr_nxt[0] = ptr_r[0];
      ptr_nxt[1] = ptr_r[1];
      zero_nxt   = zero_r;
      carry_nxt  = carry_r;
      reset_instr_flag_n_nxt = reset_instr_flag_n_r;
      madr_nxt   = madr_r;
      swr_nxt    = 1'b0;
      mif.we     = 1'b0;
      mif.wadr   = 16'h0000;
      mif.wdat   = accum_r;
      if (wr_op) begin
         unique case (op)
            MLIE_NOP     : ;
            MLIE_MOVBANK : bank_nxt = lit[4:0];
            MLIE_MOVPCH  : pch_nxt = lit[6:0];
            MLIE_MOVACC  : accum_nxt = lit;
            MLIE_STDIR   : begin
               mif.we   = 1'b1;
               mif.wadr = win_adr(fadr, ptr_r[0], ptr_r[1], fadr);
            end
            MLIE_STIND, MLIE_STREL : begin
               mif.we   = 1'b1;
               mif.wadr = eff;
               if (op == MLIE_STIND) begin
                  ptr_nxt[psel] = upd;
               end
            end
            MLIE_LDIND, MLIE_LDREL : begin
               accum_nxt = mif.rdat;
               zero_nxt  = (mif.rdat == 8'h00);
               if (op == MLIE_LDIND) begin
                  ptr_nxt[psel] = upd;
               end
            end
            MLIE_OPTION  : option_nxt = accum_r;
            MLIE_SWRESET : begin
               swr_nxt  = 1'b1;
               reset_instr_flag_n_nxt = 1'b0;
            end
            default      : ;
         endcase
      end else if (req & wb_we_i & wb_sel_i[0]) begin
         unique case (wb_adr_i)
            `MLIE_ADR_PTR0   : ptr_nxt[0] = wb_dat_i[15:0];
            `MLIE_ADR_PTR1   : ptr_nxt[1] = wb_dat_i[15:0];
            `MLIE_ADR_MEMADR : madr_nxt = wb_dat_i[15:0];
            `MLIE_ADR_MEMDAT : begin
               mif.we   = 1'b1;
               mif.wadr = madr_r;
               mif.wdat = wb_dat_i[7:0];
            end
            `MLIE_ADR_SUPPLY : reset_instr_flag_n_nxt = reset_instr_flag_n_r | wb_dat_i[0];
            default          : ;
         endcase
      end
   end

   always_comb begin
      ack_nxt  = req;
      rdat_nxt = 32'h0000_0000;
      unique case (wb_adr_i)
         `MLIE_ADR_ACCUM  : rdat_nxt = {24'h000000, accum_r};
         `MLIE_ADR_BANK   : rdat_nxt = {27'h0000000, bank_r};
         `MLIE_ADR_PCH    : rdat_nxt = {25'h0000000, pch_r};
         `MLIE_ADR_OPTION : rdat_nxt = {24'h000000, option_r};
         `MLIE_ADR_PTR0   : rdat_nxt = {16'h0000, ptr_r[0]};
         `MLIE_ADR_PTR1   : rdat_nxt = {16'h0000, ptr_r[1]};
         `MLIE_ADR_STATUS : rdat_nxt = {30'h00000000, zero_r, carry_r};
         `MLIE_ADR_MEMADR : rdat_nxt = {16'h0000, madr_r};
         `MLIE_ADR_MEMDAT : rdat_nxt = {24'h000000, mif.rdat};
         `MLIE_ADR_SUPPLY : rdat_nxt = {31'h00000000, reset_instr_flag_n_r};
         default          : rdat_nxt = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i | swr_r) begin
         accum_r  <= 8'h00;
         bank_r   <= 5'h00;
         pch_r    <= 7'h00;
         option_r <= `MLIE_OPT_RESET;
         ptr_r[0] <= 16'h0000;
         ptr_r[1] <= 16'h0000;
         zero_r   <= 1'b0;
         carry_r  <= 1'b0;
         madr_r   <= 16'h0000;
         ack_r    <= 1'b0;
         swr_r    <= 1'b0;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         sw_reset_o <= 1'b0;
      end else begin
         accum_r  <= accum_nxt;
         bank_r   <= bank_nxt;
         pch_r    <= pch_nxt;
         option_r <= option_nxt;
         ptr_r[0] <= ptr_nxt[0];
         ptr_r[1] <= ptr_nxt[1];
         zero_r   <= zero_nxt;
         carry_r  <= carry_nxt;
         madr_r   <= madr_nxt;
         ack_r    <= ack_nxt;
         swr_r    <= swr_nxt;
         wb_ack_o <= ack_nxt;
         wb_dat_o <= rdat_nxt;
         sw_reset_o <= swr_nxt;
      end
   end

   // reset-cause flag survives the software reset it records
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         reset_instr_flag_n_r <= 1'b1;
      end else begin
         reset_instr_flag_n_r <= reset_instr_flag_n_nxt;
      end
   end

   chk_bank_load : assert property (@(posedge clk_i) disable iff (rst_i)
      wr_op && op == MLIE_MOVBANK && !swr_r |=> bank_r == $past(wb_dat_i[4:0]))
      else $error("bank select not loaded");
   chk_pch_load : assert property (@(posedge clk_i) disable iff (rst_i)
      wr_op && op == MLIE_MOVPCH && !swr_r |=> pch_r == $past(wb_dat_i[6:0]))
      else $error("pc high latch not loaded");
   chk_accum_load : assert property (@(posedge clk_i) disable iff (rst_i)
      wr_op && op == MLIE_MOVACC && !swr_r |=> accum_r == $past(wb_dat_i[7:0]))
      else $error("accumulator not loaded");
   chk_direct_store : assert property (@(posedge clk_i) disable iff (rst_i)
      wr_op && op == MLIE_STDIR && fadr > 7'h01 |-> mif.we && mif.wadr == {9'h000, fadr})
      else $error("direct store address wrong");
   chk_rel_ptr_kept : assert property (@(posedge clk_i) disable iff (rst_i)
      wr_op && (op == MLIE_STREL || op == MLIE_LDREL) && !swr_r
      |=> ptr_r[$past(psel)] == $past(ptr_r[psel]))
      else $error("relative access moved pointer");
   chk_ptr_step : assert property (@(posedge clk_i) disable iff (rst_i)
      wr_op && op == MLIE_STIND && pmode == MLIE_POSTINC && !swr_r
      |=> ptr_r[$past(psel)] == $past(ptr_r[psel]) + 16'h0001)
      else $error("pointer increment wrong");
   chk_flags_kept : assert property (@(posedge clk_i) disable iff (rst_i)
      wr_op && op == MLIE_STIND && !swr_r |=> $stable(zero_r) && $stable(carry_r))
      else $error("pointer update touched flags");
   chk_option_load : assert property (@(posedge clk_i) disable iff (rst_i)
      wr_op && op == MLIE_OPTION && !swr_r |=> option_r == $past(accum_r))
      else $error("option register not loaded");
   chk_swreset : assert property (@(posedge clk_i) disable iff (rst_i)
      wr_op && op == MLIE_SWRESET |=> sw_reset_o && !reset_instr_flag_n_r ##1 bank_r == 5'h00)
      else $error("software reset not executed");
   chk_zero_flag : assert property (@(posedge clk_i) disable iff (rst_i)
      wr_op && op == MLIE_LDIND && !swr_r |=> zero_r == (accum_r == 8'h00))
      else $error("zero flag not from loaded value");
endmodule : mlie_exec

/* File: tb/move_literal_indirect_exec_tb.sv */
// self-checking bench for the literal/indirect move executor
`timescale 1ns/100ps
`include "mlie_params.svh"
module move_literal_indirect_exec_tb;
   import mlie_pkg::*;
   logic        clk_i, rst_i, cyc, stb, we, sw_reset_o, wb_ack_o;
   logic [3:0]  adr, sel;
   logic [31:0] dat, wb_dat_o, lfsr_r, v, r;
   logic [31:0] exp_q[$];
   string       name_q[$];
   int          mismatches, total_checks, pulses;
   logic [15:0] adr_t[4] = '{16'h0011, 16'h000F, 16'h0010, 16'h0010};
   logic [15:0] ptr_t[4] = '{16'h0011, 16'h000F, 16'h0011, 16'h000F};

   mlie_exec dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sw_reset_o(sw_reset_o));

   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   function automatic logic [31:0] rnd();
      lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
      return lfsr_r;
   endfunction : rnd

   task automatic check(string nm, logic [31:0] seen, logic [31:0] expv);
      total_checks++;
      if (seen !== expv) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", nm, expv, seen);
      end
   endtask : check

   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run

   task automatic wb(logic w, logic [3:0] i, logic [31:0] d);
      int n;
      @(posedge clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= i; sel <= 4'hF; dat <= d;
      n = 0;
      // hold the request until the rising edge that samples ack high
      do begin
         @(posedge clk_i);
         n++;
         if (n > 50) begin
            mismatches++;
            complete_run();
         end
      end while (wb_ack_o !== 1'b1);
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
   endtask : wb

   task automatic wr(logic [3:0] i, logic [31:0] d);
      wb(1'b1, i, d);
   endtask : wr

   task automatic rd(string nm, logic [3:0] i, logic [31:0] e);
      exp_q.push_back(e);
      name_q.push_back(nm);
      wb(1'b0, i, 32'h0);
   endtask : rd

   task automatic ex(mlie_op_type op, logic [1:0] md, logic ps, logic [7:0] lit);
      wr(`MLIE_ADR_OPCODE, {12'h000, op, 5'h00, md, ps, lit});
   endtask : ex

   task automatic mem_chk(logic [15:0] a, logic [7:0] e);
      wr(`MLIE_ADR_MEMADR, {16'h0, a});
      rd("memory", `MLIE_ADR_MEMDAT, {24'h0, e});
   endtask : mem_chk

   // read results taken at the ack edge, compared in order of issue
   always @(posedge clk_i) begin
      if (wb_ack_o === 1'b1 && we === 1'b0) begin
         if (exp_q.size() == 0) check("spare ack", 32'h1, 32'h0);
         else check(name_q.pop_front(), wb_dat_o, exp_q.pop_front());
      end
      if (sw_reset_o === 1'b1) pulses++;
   end

   initial begin
      lfsr_r = 32'h0001_27EB;
      cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 4'h0; sel = 4'h0; dat = 32'h0;
      rst_i = 1'b1;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      rd("option", `MLIE_ADR_OPTION, 32'hFF);
      rd("supply", `MLIE_ADR_SUPPLY, 32'h1);
      rd("unmapped", 4'hF, 32'h0);
      v = rnd() & 32'h1F;
      ex(MLIE_MOVBANK, 2'b00, 1'b0, v[7:0]);
      rd("bank", `MLIE_ADR_BANK, v);
      v = rnd() & 32'h7F;
      ex(MLIE_MOVPCH, 2'b00, 1'b0, v[7:0]);
      rd("pc high", `MLIE_ADR_PCH, v);
      v = rnd() & 32'hFF;
      ex(MLIE_MOVACC, 2'b00, 1'b0, v[7:0]);
      rd("accum", `MLIE_ADR_ACCUM, v);
      ex(MLIE_STDIR, 2'b00, 1'b0, 8'h25);
      mem_chk(16'h0025, v[7:0]);
      wr(`MLIE_ADR_PTR0, 32'h0040);
      ex(MLIE_STDIR, 2'b00, 1'b0, 8'h00);
      mem_chk(16'h0040, v[7:0]);
      for (int m = 0; m < 4; m++) begin
         wr(`MLIE_ADR_PTR1, 32'h0010);
         v = rnd() & 32'hFF;
         ex(MLIE_MOVACC, 2'b00, 1'b0, v[7:0]);
         ex(MLIE_STIND, m[1:0], 1'b1, 8'h00);
         mem_chk(adr_t[m], v[7:0]);
         rd("pointer1", `MLIE_ADR_PTR1, {16'h0, ptr_t[m]});
      end
      wr(`MLIE_ADR_PTR0, 32'hFFFF);
      ex(MLIE_STIND, 2'b00, 1'b0, 8'h00);
      rd("pointer0", `MLIE_ADR_PTR0, 32'h0);
      mem_chk(16'h0000, v[7:0]);
      ex(MLIE_STIND, 2'b11, 1'b0, 8'h00);
      rd("pointer0", `MLIE_ADR_PTR0, 32'hFFFF);
      rd("status", `MLIE_ADR_STATUS, 32'h0);
      wr(`MLIE_ADR_PTR0, 32'h0050);
      ex(MLIE_STREL, 2'b00, 1'b0, 8'h20);
      ex(MLIE_STREL, 2'b00, 1'b0, 8'h1F);
      mem_chk(16'h0030, v[7:0]);
      mem_chk(16'h006F, v[7:0]);
      rd("pointer0", `MLIE_ADR_PTR0, 32'h0050);
      wr(`MLIE_ADR_MEMADR, 32'h80);
      wr(`MLIE_ADR_MEMDAT, 32'h0);
      wr(`MLIE_ADR_PTR1, 32'h007F);
      ex(MLIE_LDIND, 2'b00, 1'b1, 8'h00);
      rd("accum", `MLIE_ADR_ACCUM, 32'h0);
      rd("status", `MLIE_ADR_STATUS, 32'h2);
      rd("pointer1", `MLIE_ADR_PTR1, 32'h0080);
      r = (rnd() & 32'hFF) | 32'h1;
      wr(`MLIE_ADR_MEMADR, 32'h90);
      wr(`MLIE_ADR_MEMDAT, r);
      wr(`MLIE_ADR_PTR0, 32'h0088);
      ex(MLIE_LDREL, 2'b00, 1'b0, 8'h08);
      rd("accum", `MLIE_ADR_ACCUM, r);
      rd("status", `MLIE_ADR_STATUS, 32'h0);
      ex(MLIE_OPTION, 2'b00, 1'b0, 8'h00);
      rd("option", `MLIE_ADR_OPTION, r);
      ex(MLIE_NOP, 2'b00, 1'b0, 8'h00);
      rd("accum", `MLIE_ADR_ACCUM, r);
      rd("pointer0", `MLIE_ADR_PTR0, 32'h0088);
      ex(MLIE_SWRESET, 2'b00, 1'b0, 8'h00);
      repeat (3) @(posedge clk_i);
      rd("supply", `MLIE_ADR_SUPPLY, 32'h0);
      rd("option", `MLIE_ADR_OPTION, 32'hFF);
      rd("accum", `MLIE_ADR_ACCUM, 32'h0);
      wr(`MLIE_ADR_SUPPLY, 32'h1);
      rd("supply", `MLIE_ADR_SUPPLY, 32'h1);
      repeat (3) @(posedge clk_i);
      check("reset pulses", pulses, 32'h1);
      check("pending reads", exp_q.size(), 32'h0);
      complete_run();
   end
endmodule : move_literal_indirect_exec_tb
